// ==== src/pcf_pkg.sv ====
// Constants shared by the counter enable and freeze logic
package pcf_pkg;
  // Counter population and widths
  localparam int PCF_NUM_GP = 4;
  localparam int PCF_NUM_FX = 3;
  localparam int PCF_NUM_THR = 2;
  localparam int PCF_CTR_W = 48;
  localparam logic [7:0] PCF_VERSION = 8'h04;
  // Register addresses
  localparam logic [31:0] PCF_EVTSEL_BASE = 32'h0000_0186;
  localparam logic [31:0] PCF_FX_CTR_BASE = 32'h0000_0309;
  localparam logic [31:0] PCF_GP_CTR_BASE = 32'h0000_04c1;
  localparam logic [31:0] PCF_FX_CTL_ADDR = 32'h0000_0500;
  localparam logic [31:0] PCF_STATUS_ADDR = 32'h0000_0501;
  localparam logic [31:0] PCF_GEN_ADDR = 32'h0000_0502;
  localparam logic [31:0] PCF_OVF_CLR_ADDR = 32'h0000_0503;
  localparam logic [31:0] PCF_DBG_ADDR = 32'h0000_0504;
  localparam logic [31:0] PCF_CAPS_ADDR = 32'h0000_0505;
  // Event select fields
  localparam int PCF_EVT_USR = 16;
  localparam int PCF_EVT_OS = 17;
  localparam int PCF_EVT_INT = 20;
  localparam int PCF_EVT_ANY = 21;
  localparam int PCF_EVT_EN = 22;
  // Fixed control group fields
  localparam int PCF_FX_GRP_W = 4;
  localparam int PCF_FX_OS = 0;
  localparam int PCF_FX_USR = 1;
  localparam int PCF_FX_ANY = 2;
  localparam int PCF_FX_PMI = 3;
  // Global status fields
  localparam int PCF_ST_FX_BASE = 32;
  localparam int PCF_ST_TRACE = 55;
  localparam int PCF_ST_BR_FRZ = 58;
  localparam int PCF_ST_COUNTERS_FROZEN = 59;
  localparam int PCF_ST_ENCL = 60;
  // Debug control fields
  localparam int PCF_DBG_BR_EN = 0;
  localparam int PCF_DBG_FRZ_BR = 11;
  localparam int PCF_DBG_FRZ_CTR = 12;
  localparam logic [63:0] PCF_DBG_MASK = 64'h0000_0000_0000_1801;
  // Capability field
  localparam int PCF_CAP_NGP_LSB = 8;
endpackage : pcf_pkg

// ==== src/pcf_ctr_if.sv ====
// Link between the control logic and one counter
interface pcf_ctr_if #(
  parameter int W = 48,
  parameter int IW = 2
);
  logic [IW-1:0] inc;
  logic load;
  logic [W-1:0] load_val;
  logic [W-1:0] value;
  logic ovf;
  modport ctl (output inc, load, load_val, input value, ovf);
  modport ctr (input inc, load, load_val, output value, ovf);
endinterface : pcf_ctr_if

// ==== src/pcf_counter.sv ====
// One performance counter with load and wrap pulse
module pcf_counter #(
  parameter int W = 48,
  parameter int IW = 2
) (
  input wire logic clk_in,   // Core clock
  input wire logic rst_in,   // Async reset, active high
  pcf_ctr_if.ctr bus         // Increment, load and value
);
  logic [W-1:0] value_q;
  logic [W-1:0] value_d;
  logic ovf_q;
  logic ovf_d;
  logic [W:0] sum;

  always_comb begin
    sum = {1'b0, value_q} + (W+1)'(bus.inc);
    value_d = bus.load ? bus.load_val : sum[W-1:0];
    ovf_d = !bus.load && sum[W];
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      value_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      value_q <= value_d;
      ovf_q <= ovf_d;
    end
  end

  assign bus.value = value_q;
  assign bus.ovf = ovf_q;
endmodule // pcf_counter

// ==== src/pcf_core.sv ====
// Counter enable, cross-thread counting, global status and freeze
module pcf_core
  import pcf_pkg::*;
#(
  parameter int NUM_GP = PCF_NUM_GP,
  parameter int NUM_FX = PCF_NUM_FX,
  parameter int NUM_THR = PCF_NUM_THR,
  parameter int CTR_W = PCF_CTR_W,
  parameter bit TRACE_SUPPORTED = 1'b1
) (
  input wire logic clk_in,                           // Core clock
  input wire logic rst_in,                           // Async reset, active high
  input wire logic msr_req_in,                       // Register access request
  input wire logic msr_wr_in,                        // 1 write, 0 read
  input wire logic [31:0] msr_addr_in,               // Register address
  input wire logic [NUM_THR-1:0] msr_thread_in,      // One-hot requesting thread
  input wire logic [63:0] msr_wdata_in,              // Write data
  output logic msr_ack_out,                          // Access done pulse
  output logic msr_fault_out,                        // Unmapped address with ack
  output logic [63:0] msr_rdata_out,                 // Read data with ack
  input wire logic [NUM_GP*NUM_THR-1:0] gp_event_in, // Event per general counter per thread
  input wire logic [NUM_FX*NUM_THR-1:0] fx_event_in, // Event per fixed counter per thread
  input wire logic [NUM_THR-1:0] thread_user_in,     // Thread runs at user privilege
  input wire logic trace_full_irq_in,                // Trace buffer full pulse
  input wire logic enclave_active_in,                // Enclave protection active
  output logic perf_interrupt_out,                   // Performance interrupt pulse
  output logic branch_capture_en_out,                // Branch record capture allowed
  output logic counters_frozen_out                   // All counting stopped
);
  localparam int NC = NUM_GP + NUM_FX;
  localparam int IW = $clog2(NUM_THR + 1);
  localparam logic [63:0] CTR_MASK = 64'((64'h1 << NUM_GP) - 64'h1)
    | (64'((64'h1 << NUM_FX) - 64'h1) << PCF_ST_FX_BASE);
  localparam logic [63:0] ST_MASK = CTR_MASK | (64'h1 << PCF_ST_BR_FRZ) | (64'h1 << PCF_ST_COUNTERS_FROZEN)
    | (64'h1 << PCF_ST_ENCL) | (64'(TRACE_SUPPORTED) << PCF_ST_TRACE);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [63:0] evtsel_q [NUM_GP];
  logic [63:0] evtsel_d [NUM_GP];
  logic [NUM_THR-1:0] gp_own_q [NUM_GP];
  logic [NUM_THR-1:0] gp_own_d [NUM_GP];
  logic [PCF_FX_GRP_W*NUM_FX-1:0] fxctl_q;
  logic [PCF_FX_GRP_W*NUM_FX-1:0] fxctl_d;
  logic [NUM_THR-1:0] fx_own_q;
  logic [NUM_THR-1:0] fx_own_d;
  logic [63:0] gen_q;
  logic [63:0] gen_d;
  logic [63:0] dbg_q;
  logic [63:0] dbg_d;
  logic wr;

  assign wr = msr_req_in && msr_wr_in;

  always_comb begin
    evtsel_d = evtsel_q;
    gp_own_d = gp_own_q;
    fxctl_d = fxctl_q;
    fx_own_d = fx_own_q;
    gen_d = gen_q;
    dbg_d = dbg_q;
    for (int n = 0; n < NUM_GP; n++) begin
      if (wr && msr_addr_in == PCF_EVTSEL_BASE + 32'(n)) begin
        evtsel_d[n] = msr_wdata_in;
        gp_own_d[n] = msr_thread_in;
      end
    end
    if (wr && msr_addr_in == PCF_FX_CTL_ADDR) begin
      fxctl_d = msr_wdata_in[PCF_FX_GRP_W*NUM_FX-1:0];
      fx_own_d = msr_thread_in;
    end
    if (wr && msr_addr_in == PCF_GEN_ADDR) begin
      gen_d = msr_wdata_in & CTR_MASK;
    end
    if (wr && msr_addr_in == PCF_DBG_ADDR) begin
      dbg_d = msr_wdata_in & PCF_DBG_MASK;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int n = 0; n < NUM_GP; n++) begin
        evtsel_q[n] <= '0;
        gp_own_q[n] <= '0;
      end
      fxctl_q <= '0;
      fx_own_q <= '0;
      gen_q <= '0;
      dbg_q <= '0;
    end else begin
      evtsel_q <= evtsel_d;
      gp_own_q <= gp_own_d;
      fxctl_q <= fxctl_d;
      fx_own_q <= fx_own_d;
      gen_q <= gen_d;
      dbg_q <= dbg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters
  logic [IW-1:0] inc_w [NC];
  logic load_w [NC];
  logic [CTR_W-1:0] ctr_val [NC];
  logic ctr_ovf [NC];
  logic pmi_en [NC];
  logic [63:0] status_q;

  // A counter load wins over counting in its cycle and raises no wrap pulse
  for (genvar i = 0; i < NC; i++) begin : g_ctr
    pcf_ctr_if #(.W(CTR_W), .IW(IW)) link ();
    pcf_counter #(.W(CTR_W), .IW(IW)) u_ctr (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .bus(link)
    );
    assign link.inc = inc_w[i];
    assign link.load = load_w[i];
    assign link.load_val = msr_wdata_in[CTR_W-1:0];
    assign ctr_val[i] = link.value;
    assign ctr_ovf[i] = link.ovf;
  end

  always_comb begin
    logic en;
    logic any;
    logic usr;
    logic os;
    logic ev;
    logic [NUM_THR-1:0] own;
    logic [IW-1:0] cnt;
    en = 1'b0;
    any = 1'b0;
    usr = 1'b0;
    os = 1'b0;
    ev = 1'b0;
    own = '0;
    cnt = '0;
    for (int i = 0; i < NC; i++) begin
      if (i < NUM_GP) begin
        en = evtsel_q[i][PCF_EVT_EN] && gen_q[i] && !status_q[PCF_ST_COUNTERS_FROZEN];
        any = evtsel_q[i][PCF_EVT_ANY];
        usr = evtsel_q[i][PCF_EVT_USR];
        os = evtsel_q[i][PCF_EVT_OS];
        own = gp_own_q[i];
        pmi_en[i] = evtsel_q[i][PCF_EVT_INT];
        load_w[i] = wr && msr_addr_in == PCF_GP_CTR_BASE + 32'(i);
      end else begin
        usr = fxctl_q[PCF_FX_GRP_W*(i-NUM_GP)+PCF_FX_USR];
        os = fxctl_q[PCF_FX_GRP_W*(i-NUM_GP)+PCF_FX_OS];
        en = (usr || os) && gen_q[PCF_ST_FX_BASE+i-NUM_GP] && !status_q[PCF_ST_COUNTERS_FROZEN];
        any = fxctl_q[PCF_FX_GRP_W*(i-NUM_GP)+PCF_FX_ANY];
        own = fx_own_q;
        pmi_en[i] = fxctl_q[PCF_FX_GRP_W*(i-NUM_GP)+PCF_FX_PMI];
        load_w[i] = wr && msr_addr_in == PCF_FX_CTR_BASE + 32'(i - NUM_GP);
      end
      cnt = '0;
      for (int t = 0; t < NUM_THR; t++) begin
        ev = (i < NUM_GP) ? gp_event_in[i*NUM_THR+t] : fx_event_in[(i-NUM_GP)*NUM_THR+t];
        // Privilege filter of each thread, then thread scope
        if (ev && ((usr && thread_user_in[t]) || (os && !thread_user_in[t]))
            && (any || own[t])) begin
          cnt = cnt + IW'(1);
        end
      end
      inc_w[i] = en ? cnt : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global status and freeze
  logic [63:0] status_d;
  logic perf_int_q;
  logic perf_int_d;
  logic br_cap_q;
  logic br_cap_d;

  always_comb begin
    logic [63:0] set;
    logic [63:0] clr;
    logic perf_interrupt;
    logic counting;
    set = '0;
    clr = '0;
    perf_interrupt = 1'b0;
    counting = 1'b0;
    for (int i = 0; i < NC; i++) begin
      if (ctr_ovf[i]) begin
        set[(i < NUM_GP) ? i : PCF_ST_FX_BASE + i - NUM_GP] = 1'b1;
        perf_interrupt = perf_interrupt || pmi_en[i];
      end
      counting = counting || (inc_w[i] != '0);
    end
    // Only the status-driven freeze exists; besides it, the enable bits and gen_q gate counting
    if (perf_interrupt && dbg_q[PCF_DBG_FRZ_BR]) begin
      set[PCF_ST_BR_FRZ] = 1'b1;
    end
    if (perf_interrupt && dbg_q[PCF_DBG_FRZ_CTR]) begin
      set[PCF_ST_COUNTERS_FROZEN] = 1'b1;
    end
    if (TRACE_SUPPORTED && trace_full_irq_in) begin
      set[PCF_ST_TRACE] = 1'b1;
    end
    if (enclave_active_in && counting) begin
      set[PCF_ST_ENCL] = 1'b1;
    end
    clr = (wr && msr_addr_in == PCF_OVF_CLR_ADDR) ? msr_wdata_in : '0;
    // A new event in the clearing cycle survives the clear
    status_d = ((status_q & ~clr) | set) & ST_MASK;
    perf_int_d = perf_interrupt || (TRACE_SUPPORTED && trace_full_irq_in);
    br_cap_d = dbg_q[PCF_DBG_BR_EN] && !status_d[PCF_ST_BR_FRZ];
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_q <= '0;
      perf_int_q <= 1'b0;
      br_cap_q <= 1'b0;
    end else begin
      status_q <= status_d;
      perf_int_q <= perf_int_d;
      br_cap_q <= br_cap_d;
    end
  end

  assign perf_interrupt_out = perf_int_q;
  assign branch_capture_en_out = br_cap_q;
  assign counters_frozen_out = status_q[PCF_ST_COUNTERS_FROZEN];

  ////////////////////////////////////////////////////////////////////////////
  // Register read and answer
  logic ack_q;
  logic ack_d;
  logic fault_q;
  logic fault_d;
  logic [63:0] rdata_q;
  logic [63:0] rdata_d;

  always_comb begin
    logic hit;
    logic [63:0] val;
    hit = 1'b1;
    val = '0;
    unique case (msr_addr_in)
      PCF_FX_CTL_ADDR: val = 64'(fxctl_q);
      PCF_STATUS_ADDR: val = status_q;
      PCF_GEN_ADDR: val = gen_q;
      PCF_OVF_CLR_ADDR: val = '0;
      PCF_DBG_ADDR: val = dbg_q;
      PCF_CAPS_ADDR: val = 64'({8'(NUM_GP), PCF_VERSION});
      default: begin
        hit = 1'b0;
        for (int n = 0; n < NUM_GP; n++) begin
          if (msr_addr_in == PCF_EVTSEL_BASE + 32'(n)) begin
            hit = 1'b1;
            val = evtsel_q[n];
          end
          if (msr_addr_in == PCF_GP_CTR_BASE + 32'(n)) begin
            hit = 1'b1;
            val = 64'(ctr_val[n]);
          end
        end
        for (int j = 0; j < NUM_FX; j++) begin
          if (msr_addr_in == PCF_FX_CTR_BASE + 32'(j)) begin
            hit = 1'b1;
            val = 64'(ctr_val[NUM_GP+j]);
          end
        end
      end
    endcase
    ack_d = msr_req_in;
    fault_d = msr_req_in && !hit;
    rdata_d = (msr_req_in && !msr_wr_in && hit) ? val : '0;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
      fault_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= ack_d;
      fault_q <= fault_d;
      rdata_q <= rdata_d;
    end
  end

  assign msr_ack_out = ack_q;
  assign msr_fault_out = fault_q;
  assign msr_rdata_out = rdata_q;
endmodule // pcf_core

// ==== testbench/pcf_core_sva.sv ====
// Port assertions for the counter enable and freeze block
module pcf_core_sva
  import pcf_pkg::*;
#(
  parameter int NUM_GP = 4,
  parameter int NUM_FX = 3
) (
  input wire logic clk_in,                // Core clock
  input wire logic rst_in,                // Async reset
  input wire logic msr_req_in,            // Access request
  input wire logic msr_wr_in,             // Write select
  input wire logic [31:0] msr_addr_in,    // Address
  input wire logic [63:0] msr_wdata_in,   // Write data
  input wire logic msr_ack_out,           // Access done
  input wire logic msr_fault_out,         // Unmapped address
  input wire logic [63:0] msr_rdata_out,  // Read data
  input wire logic trace_full_irq_in,     // Trace buffer full
  input wire logic perf_interrupt_out,    // Interrupt pulse
  input wire logic branch_capture_en_out, // Branch capture allowed
  input wire logic counters_frozen_out    // Counting stopped
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic clr_frz;
  logic dbg_wr;
  assign clr_frz = msr_req_in & msr_wr_in & (msr_addr_in == PCF_OVF_CLR_ADDR) & msr_wdata_in[PCF_ST_COUNTERS_FROZEN];
  assign dbg_wr = msr_req_in & msr_wr_in & (msr_addr_in == PCF_DBG_ADDR);

  ack_after_req_a: assert property (msr_req_in |=> msr_ack_out)
    else $error("request not acknowledged next cycle");
  ack_idle_a: assert property (!msr_req_in |=> !msr_ack_out && !msr_fault_out)
    else $error("acknowledge without request");
  rdata_idle_a: assert property (!msr_ack_out |-> msr_rdata_out == 64'h0)
    else $error("read data outside acknowledge");
  map_ok_a: assert property (msr_req_in && ((msr_addr_in - PCF_EVTSEL_BASE) < 32'(NUM_GP)
    || (msr_addr_in - PCF_FX_CTR_BASE) < 32'(NUM_FX)) |=> msr_ack_out && !msr_fault_out)
    else $error("mapped control register faulted");
  map_hole_a: assert property (msr_req_in && (msr_addr_in == PCF_EVTSEL_BASE + 32'(NUM_GP)
    || msr_addr_in == PCF_FX_CTR_BASE + 32'(NUM_FX)) |=> msr_fault_out)
    else $error("address past last counter not refused");
  trace_irq_a: assert property (trace_full_irq_in |=> perf_interrupt_out)
    else $error("trace full gave no interrupt");
  freeze_cause_a: assert property ($rose(counters_frozen_out) |-> perf_interrupt_out)
    else $error("counters froze without interrupt");
  freeze_clear_a: assert property ($fell(counters_frozen_out) |-> $past(clr_frz) || $past(clr_frz, 2))
    else $error("freeze released without clear write");
  branch_fall_a: assert property ($fell(branch_capture_en_out) |-> perf_interrupt_out
    || $past(dbg_wr) || $past(dbg_wr, 2))
    else $error("branch capture dropped without cause");
endmodule // pcf_core_sva

bind pcf_core pcf_core_sva #(.NUM_GP(NUM_GP), .NUM_FX(NUM_FX)) chk (.clk_in(clk_in), .rst_in(rst_in),
  .msr_req_in(msr_req_in), .msr_wr_in(msr_wr_in), .msr_addr_in(msr_addr_in), .msr_wdata_in(msr_wdata_in),
  .msr_ack_out(msr_ack_out), .msr_fault_out(msr_fault_out), .msr_rdata_out(msr_rdata_out),
  .trace_full_irq_in(trace_full_irq_in), .perf_interrupt_out(perf_interrupt_out),
  .branch_capture_en_out(branch_capture_en_out), .counters_frozen_out(counters_frozen_out));

// ==== testbench/pcf_evt_model.sv ====
// Event sources of the threads sharing the core
module pcf_evt_model #(
  parameter int GP_W = 8,
  parameter int FX_W = 6
) (
  input wire logic clk_in,        // Core clock
  output logic [GP_W-1:0] gp_out, // General counter events
  output logic [FX_W-1:0] fx_out, // Fixed counter events
  output logic [1:0] user_out     // Threads at user privilege
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    gp_out = '0;
    fx_out = '0;
    user_out = 2'h3;
  end
  // Events stand from a falling edge for n cycles, then are withdrawn
  task automatic burst(input logic [GP_W-1:0] gp, input logic [FX_W-1:0] fx, input int n);
    gp_out = gp;
    fx_out = fx;
    repeat (n) @(negedge clk_in);
    gp_out = '0;
    fx_out = '0;
  endtask
  // Privilege of each thread, changed at a falling edge by the caller
  task automatic set_user(input logic [1:0] u);
    user_out = u;
  endtask
endmodule // pcf_evt_model

// ==== testbench/tb.sv ====
// Self-checking bench for the counter enable and freeze block
module tb
  import pcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic msr_req_in = 1'b0;
  logic msr_wr_in = 1'b0;
  logic [31:0] msr_addr_in = 32'h0;
  logic [1:0] msr_thread_in = 2'h1;
  logic [63:0] msr_wdata_in = 64'h0;
  logic trace_full_irq_in = 1'b0;
  logic enclave_active_in = 1'b0;
  logic msr_ack_out, msr_fault_out, perf_interrupt_out, branch_capture_en_out, counters_frozen_out, flt;
  logic [63:0] msr_rdata_out, rd;
  logic [7:0] gp_event_in;
  logic [5:0] fx_event_in;
  logic [1:0] thread_user_in;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #5 clk_in = ~clk_in;

  pcf_core uut (.clk_in(clk_in), .rst_in(rst_in), .msr_req_in(msr_req_in), .msr_wr_in(msr_wr_in),
    .msr_addr_in(msr_addr_in), .msr_thread_in(msr_thread_in), .msr_wdata_in(msr_wdata_in),
    .msr_ack_out(msr_ack_out), .msr_fault_out(msr_fault_out), .msr_rdata_out(msr_rdata_out),
    .gp_event_in(gp_event_in), .fx_event_in(fx_event_in), .thread_user_in(thread_user_in),
    .trace_full_irq_in(trace_full_irq_in), .enclave_active_in(enclave_active_in),
    .perf_interrupt_out(perf_interrupt_out), .branch_capture_en_out(branch_capture_en_out),
    .counters_frozen_out(counters_frozen_out));
  pcf_evt_model evt (.clk_in(clk_in), .gp_out(gp_event_in), .fx_out(fx_event_in), .user_out(thread_user_in));

  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One access: request held through one rising edge, answer taken at the next falling edge
  task automatic acc(input logic w, input logic [31:0] a, input logic [63:0] d);
    @(negedge clk_in);
    msr_req_in = 1'b1;
    msr_wr_in = w;
    msr_addr_in = a;
    msr_wdata_in = d;
    @(negedge clk_in);
    msr_req_in = 1'b0;
    rd = msr_rdata_out;
    flt = msr_fault_out;
    chk("ack", 64'h1, 64'(msr_ack_out));
  endtask
  task automatic wr(input logic [31:0] a, input logic [63:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [31:0] a, input logic [63:0] exp);
    acc(1'b0, a, 64'h0);
    chk(nm, exp, rd);
  endtask
  task automatic settle();
    repeat (3) @(negedge clk_in);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("BAD run_length expected finish seen hang");
      tally_and_finish();
    end
  end

  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    rdc("status_rst", PCF_STATUS_ADDR, 64'h0);
    acc(1'b0, PCF_CAPS_ADDR, 64'h0);
    chk("caps_ngp", 64'h4, 64'(rd[15:8]));
    acc(1'b0, PCF_EVTSEL_BASE + 32'h4, 64'h0);
    chk("fault", 64'h1, 64'(flt));
    wr(PCF_GEN_ADDR, 64'hffff_ffff_ffff_ffff);
    rdc("gen_mask", PCF_GEN_ADDR, 64'h0000_0007_0000_000f);
    wr(PCF_GEN_ADDR, 64'h0);
    $display("test register_map done");
    // Thread 0 owns the selects, thread 1 the fixed control
    wr(PCF_EVTSEL_BASE, 64'h0000_0000_0043_0000);
    wr(PCF_EVTSEL_BASE + 32'h1, 64'h0000_0000_0063_0000);
    wr(PCF_EVTSEL_BASE + 32'h2, 64'h0000_0000_0003_0000);
    wr(PCF_EVTSEL_BASE + 32'h3, 64'h0000_0000_0062_0000);
    msr_thread_in = 2'h2;
    wr(PCF_FX_CTL_ADDR, 64'h073);
    msr_thread_in = 2'h1;
    wr(PCF_GEN_ADDR, 64'h0000_0007_0000_000f);
    evt.burst(8'hff, 6'h3f, 5);
    settle();
    rdc("gp_own", PCF_GP_CTR_BASE, 64'h5);
    rdc("gp_any", PCF_GP_CTR_BASE + 32'h1, 64'ha);
    rdc("gp_off", PCF_GP_CTR_BASE + 32'h2, 64'h0);
    rdc("gp_priv", PCF_GP_CTR_BASE + 32'h3, 64'h0);
    rdc("fx_own", PCF_FX_CTR_BASE, 64'h5);
    rdc("fx_any", PCF_FX_CTR_BASE + 32'h1, 64'ha);
    rdc("fx_off", PCF_FX_CTR_BASE + 32'h2, 64'h0);
    $display("test cross_thread done");
    wr(PCF_DBG_ADDR, 64'h1801);
    // Capture enable follows the debug register one cycle later
    @(negedge clk_in);
    chk("brcap_on", 64'h1, 64'(branch_capture_en_out));
    wr(PCF_EVTSEL_BASE, 64'h0000_0000_0053_0000);
    wr(PCF_GP_CTR_BASE, 64'h0000_ffff_ffff_ffff);
    evt.burst(8'h01, 6'h00, 1);
    settle();
    chk("frozen", 64'h1, 64'(counters_frozen_out));
    chk("brcap_frz", 64'h0, 64'(branch_capture_en_out));
    rdc("st_frz", PCF_STATUS_ADDR, 64'h0c00_0000_0000_0001);
    evt.burst(8'h01, 6'h00, 3);
    settle();
    rdc("gp_held", PCF_GP_CTR_BASE, 64'h0);
    $display("test freeze done");
    wr(PCF_OVF_CLR_ADDR, 64'h0400_0000_0000_0000);
    rdc("st_part", PCF_STATUS_ADDR, 64'h0800_0000_0000_0001);
    chk("brcap_back", 64'h1, 64'(branch_capture_en_out));
    wr(PCF_OVF_CLR_ADDR, 64'h0800_0000_0000_0001);
    rdc("st_clr", PCF_STATUS_ADDR, 64'h0);
    chk("unfrozen", 64'h0, 64'(counters_frozen_out));
    rdc("clr_read", PCF_OVF_CLR_ADDR, 64'h0);
    evt.burst(8'h01, 6'h00, 2);
    settle();
    rdc("gp_resume", PCF_GP_CTR_BASE, 64'h2);
    $display("test clear done");
    trace_full_irq_in = 1'b1;
    enclave_active_in = 1'b1;
    evt.burst(8'h01, 6'h00, 1);
    chk("trace_irq", 64'h1, 64'(perf_interrupt_out));
    trace_full_irq_in = 1'b0;
    enclave_active_in = 1'b0;
    settle();
    chk("trace_nofrz", 64'h0, 64'(counters_frozen_out));
    wr(PCF_STATUS_ADDR, 64'hffff_ffff_ffff_ffff);
    rdc("st_side", PCF_STATUS_ADDR, 64'h1080_0000_0000_0000);
    $display("test side_flags done");
    wr(PCF_FX_CTL_ADDR, 64'h00b);
    wr(PCF_FX_CTR_BASE, 64'h0000_ffff_ffff_ffff);
    evt.burst(8'h00, 6'h01, 1);
    settle();
    rdc("st_fx_ovf", PCF_STATUS_ADDR, 64'h1c80_0001_0000_0000);
    wr(PCF_OVF_CLR_ADDR, 64'hffff_ffff_ffff_ffff);
    chk("fx_unfrozen", 64'h0, 64'(counters_frozen_out));
    // Thread 0 drops the cross-thread bit of a select, threads go to kernel level
    wr(PCF_EVTSEL_BASE + 32'h1, 64'h0000_0000_0043_0000);
    evt.set_user(2'h0);
    evt.burst(8'hcc, 6'h00, 1);
    settle();
    rdc("gp_scope", PCF_GP_CTR_BASE + 32'h1, 64'hb);
    rdc("gp_kernel", PCF_GP_CTR_BASE + 32'h3, 64'h2);
    $display("test fixed_and_scope done");
    tally_and_finish();
  end
endmodule // tb
